// ==== rtl/ces_pkg.sv ====
// Purpose: Shared constants for the catastrophic error signalling block
// Assumes: One system clock; bus clock events arrive as a sampled pin
// Notes:   Counts are in bus clock cycles, not system clock cycles
package ces_pkg;
  localparam int unsigned CES_MC_PULSE_BCLKS = 16;      // Machine-check pulse length in bus clocks
  localparam int unsigned CES_CNT_W          = 5;       // Width of the pulse counter
  localparam int unsigned CES_BPM_W          = 8;       // Breakpoint/monitor bus width
  localparam logic [7:0]  CES_BPM_RESET      = 8'h00;   // Active-high status after reset (all released)
  localparam int unsigned CES_SYNC_STAGES    = 2;       // Stages in each pin synchroniser

  // Drive state of the shared error line
  typedef enum logic [1:0] {
    CES_IDLE,
    CES_PULSE,
    CES_HOLD
  } ces_state_t;
endpackage : ces_pkg

// ==== rtl/ces_sync.sv ====
// Purpose: Two-flop synchroniser for a vector of pins
// Assumes: Inputs are asynchronous to sys_clk_i
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module ces_sync #(
  parameter int unsigned WIDTH = 1,       // Number of bits
  parameter logic [WIDTH-1:0] INIT = '0   // Value held during reset
) (
  input  wire logic             sys_clk_i,  // System clock
  input  wire logic             srst_i,     // Synchronous reset
  input  wire logic [WIDTH-1:0] async_i,    // Raw pin levels
  output logic      [WIDTH-1:0] sync_o      // Synchronised levels
);
  logic [WIDTH-1:0] meta;  // First stage, read only by the second

  // Two flops, nothing else reads the first
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      meta   <= INIT;
      sync_o <= INIT;
    end else begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end
endmodule : ces_sync
`default_nettype wire

// ==== rtl/ces_top.sv ====
// Purpose: Catastrophic error and debug sideband pin logic
// Assumes: bus_clk_i is a pin sampled on sys_clk_i (slower than 100 MHz)
// Notes:   warm/cold reset arrive as srst_i or warm_reset_i
`timescale 1ns/1ps
`default_nettype none
module ces_top
  import ces_pkg::*;
#(
  parameter int unsigned PULSE_BCLKS = CES_MC_PULSE_BCLKS  // Pulse length in bus clocks
) (
  input  wire logic                 sys_clk_i,            // 200 MHz system clock
  input  wire logic                 srst_i,               // Sync reset, active high (cold)
  input  wire logic                 warm_reset_i,         // Warm reset request, same domain
  input  wire logic                 bus_clk_i,            // Bus clock pin, sampled
  input  wire logic                 mc_error_i,           // Legacy machine check error event
  input  wire logic                 int_error_i,          // Legacy internal unrecoverable error
  input  wire logic [CES_BPM_W-1:0] bpm_status_i,         // Breakpoint/counter status, active high
  input  wire logic                 catastrophic_error_n_n_i,          // Error line level from pin
  output logic                      catastrophic_error_n_n_o,          // Error line output value (always 0)
  output logic                      catastrophic_error_n_n_oe_o,       // Error line pull-low enable
  input  wire logic [CES_BPM_W-1:0] bpm_n_i,              // Breakpoint bus level from pin (unused)
  output logic      [CES_BPM_W-1:0] bpm_n_o,              // Breakpoint bus output value (always 0)
  output logic      [CES_BPM_W-1:0] bpm_n_oe_o,           // Per-bit pull-low enables
  output logic                      probe_clock_out_p_o,  // Buffered bus clock to probe, true
  output logic                      probe_clock_out_n_o,  // Buffered bus clock to probe, complement
  output logic                      machine_check_o       // One-cycle machine check exception
);
  logic       cat_sync;           // Synchronised error line
  logic       bclk_sync;          // Synchronised bus clock
  logic       bclk_prev;          // Previous bus clock sample
  logic       ext_prev;           // Previous external-assert condition
  ces_state_t state;              // Error line drive state
  ces_state_t next_state;         // Next drive state
  logic [CES_CNT_W-1:0] cnt;      // Bus clock edges left in pulse
  logic [CES_CNT_W-1:0] next_cnt; // Next counter value
  logic [CES_SYNC_STAGES-1:0] own_hist; // Our recent pull-low enables

  wire bclk_rise  = bclk_sync & ~bclk_prev;            // Bus clock rising edge enable
  wire drive_low  = (state != CES_IDLE);               // We pull the line low
  // The synchronised line lags our own release by the sync depth, so it
  // stays low a few cycles after we let go; those cycles must not count.
  wire own_recent = |own_hist;                         // Line may still show our own pull
  // Line low while we are not pulling it means another agent asserts
  wire ext_assert = ~cat_sync & ~drive_low & ~catastrophic_error_n_n_oe_o & ~own_recent;
  wire any_reset  = srst_i | warm_reset_i;              // Either reset frees a held error

  // Pin synchronisers for error line and bus clock
  // Error line idles high (pull-up); bus clock starts low like bclk_prev,
  // so no false bus clock edge follows reset.
  ces_sync #(.WIDTH(2), .INIT(2'h2)) u_sync (
    .sys_clk_i (sys_clk_i),
    .srst_i    (srst_i),
    .async_i   ({catastrophic_error_n_n_i, bus_clk_i}),
    .sync_o    ({cat_sync, bclk_sync})
  );

  // Next-state selection: hold beats pulse, pulse restarts on a new event
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    case (state)
      CES_IDLE: begin
        if (int_error_i) begin
          next_state = CES_HOLD;
        end else if (mc_error_i) begin
          next_state = CES_PULSE;
          next_cnt   = CES_CNT_W'(PULSE_BCLKS);
        end
      end
      CES_PULSE: begin
        if (int_error_i) begin
          next_state = CES_HOLD;
        end else if (mc_error_i) begin
          // A repeated event reloads the full count
          next_cnt = CES_CNT_W'(PULSE_BCLKS);
        end else if (bclk_rise) begin
          // Count bus clocks; release after the last one
          next_cnt = cnt - 1'b1;
          if (cnt == CES_CNT_W'(1)) begin
            next_state = CES_IDLE;
          end
        end
      end
      CES_HOLD: begin
        next_state = CES_HOLD; // Only a reset leaves this state
      end
      default: begin
        next_state = CES_IDLE;
      end
    endcase
  end

  // State register; warm or cold reset releases a held line
  always_ff @(posedge sys_clk_i) begin
    if (any_reset) begin
      state <= CES_IDLE;
      cnt   <= '0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  // Open-drain style drive: value fixed low, enable carries the assertion
  always_ff @(posedge sys_clk_i) begin
    if (any_reset) begin
      catastrophic_error_n_n_o    <= 1'b0;
      catastrophic_error_n_n_oe_o <= 1'b0;
    end else begin
      catastrophic_error_n_n_o    <= 1'b0;
      catastrophic_error_n_n_oe_o <= (next_state != CES_IDLE);
    end
  end

  // External assertion raises one exception per low period
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      ext_prev        <= 1'b0;
      machine_check_o <= 1'b0;
      bclk_prev       <= 1'b0;
      own_hist        <= '0;
    end else begin
      ext_prev        <= ext_assert;
      machine_check_o <= ext_assert & ~ext_prev;
      bclk_prev       <= bclk_sync;
      // Mask survives warm reset: the line also settles after that release
      own_hist        <= {own_hist[CES_SYNC_STAGES-2:0], catastrophic_error_n_n_oe_o};
    end
  end

  // Breakpoint bus pulls low for each active status bit
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      bpm_n_o    <= CES_BPM_RESET;
      bpm_n_oe_o <= CES_BPM_RESET;
    end else begin
      bpm_n_o    <= CES_BPM_RESET;
      bpm_n_oe_o <= bpm_status_i;
    end
  end

  // Probe clock is a registered copy; latency two sync stages plus one.
  // Trade-off: a pin-sampled copy adds jitter of one system clock.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      probe_clock_out_p_o <= 1'b0;
      probe_clock_out_n_o <= 1'b1;
    end else begin
      probe_clock_out_p_o <= bclk_sync;
      probe_clock_out_n_o <= ~bclk_sync;
    end
  end

  // Assertions
  logic [7:0] low_cnt; // Bus clock edges seen while pulsing
  always_ff @(posedge sys_clk_i) begin
    if (any_reset || state != CES_PULSE || mc_error_i) begin
      low_cnt <= '0;
    end else if (bclk_rise) begin
      low_cnt <= low_cnt + 8'h01;
    end
  end

  AST_PULSE_LEN: assert property (@(posedge sys_clk_i) disable iff (any_reset)
    (state == CES_PULSE) |-> (low_cnt < 8'(PULSE_BCLKS)))
    else $error("pulse longer than its bus clock count");
  // Antecedents exclude a sampled reset: that edge changes state itself,
  // and disable iff alone misses a reset that ends at that very edge.
  AST_PULSE_END: assert property (@(posedge sys_clk_i) disable iff (any_reset)
    (state == CES_PULSE && !mc_error_i && !int_error_i && !any_reset && bclk_rise && cnt == CES_CNT_W'(1))
    |=> (state == CES_IDLE) && !catastrophic_error_n_n_oe_o)
    else $error("pulse not released after last bus clock");
  AST_PULSE_FULL: assert property (@(posedge sys_clk_i) disable iff (any_reset)
    (state == CES_IDLE && $past(state) == CES_PULSE && !$past(any_reset)) |-> (low_cnt == 8'(PULSE_BCLKS)))
    else $error("pulse released before its bus clock count");
  AST_MC_DRIVE: assert property (@(posedge sys_clk_i) disable iff (any_reset)
    (state == CES_IDLE && mc_error_i && !int_error_i && !any_reset) |=> catastrophic_error_n_n_oe_o && state == CES_PULSE)
    else $error("machine check error did not assert line");
  AST_HOLD: assert property (@(posedge sys_clk_i) disable iff (any_reset)
    (state == CES_HOLD && !any_reset) |=> (state == CES_HOLD) && catastrophic_error_n_n_oe_o)
    else $error("held error released without reset");
  AST_LEGACY_INTERNAL_ERROR: assert property (@(posedge sys_clk_i) disable iff (any_reset)
    (int_error_i && !any_reset) |=> (state == CES_HOLD))
    else $error("internal error not held");
  AST_EXT_MC: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (ext_assert && !ext_prev) |=> machine_check_o)
    else $error("external assertion missed machine check");
  // An exception needs three quiet cycles of our own enable
  AST_NO_SELF: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    machine_check_o |-> !$past(catastrophic_error_n_n_oe_o, 1) && !$past(catastrophic_error_n_n_oe_o, 2) && !$past(catastrophic_error_n_n_oe_o, 3))
    else $error("own assertion raised a machine check");
  AST_OD_LOW: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (catastrophic_error_n_n_o == 1'b0) && (bpm_n_o == 8'h00))
    else $error("shared line driven high");
  AST_BPM: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    !srst_i |=> (bpm_n_oe_o == $past(bpm_status_i)))
    else $error("breakpoint bus not following status");
  AST_PROBE: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    !srst_i |=> (probe_clock_out_p_o == $past(bclk_sync)) && (probe_clock_out_n_o != probe_clock_out_p_o))
    else $error("probe clock not a buffered copy");

  // Main scenarios reached
  COV_PULSE: cover property (@(posedge sys_clk_i) disable iff (any_reset)
    state == CES_PULSE ##1 state == CES_IDLE);
  COV_HOLD: cover property (@(posedge sys_clk_i) disable iff (any_reset)
    state == CES_IDLE ##1 state == CES_HOLD);
  COV_EXT: cover property (@(posedge sys_clk_i) disable iff (srst_i) machine_check_o);
  COV_WARM: cover property (@(posedge sys_clk_i) state == CES_HOLD ##1 warm_reset_i);
  COV_TO_HOLD: cover property (@(posedge sys_clk_i) disable iff (any_reset)
    state == CES_PULSE ##1 state == CES_HOLD);
endmodule : ces_top
`default_nettype wire

// ==== test/ces_peer.sv ====
// Purpose: Far side of the sideband lines: other packages and the probe
// Assumes: Both shared lines have pull-ups; bus clock runs free
// Notes:   Pulls the error line low only when the bench commands it
`timescale 1ns/1ps
`default_nettype none
module ces_peer #(
  parameter int unsigned HALF_NS = 10  // Half bus clock period, 50 MHz
) (
  input  wire logic       pull_i,     // Another agent asserts the error line
  input  wire logic       err_oe_i,   // Our pull-low enable
  input  wire logic [7:0] bpm_oe_i,   // Our breakpoint pull-low enables
  output logic            bus_clk_o,  // Free-running bus clock
  output logic            err_n_o,    // Resolved error line
  output logic [7:0]      bpm_n_o     // Resolved breakpoint bus
);
  // Offset start so bus edges never meet system clock edges
  initial begin
    bus_clk_o = 1'b0;
    #3;
    forever #HALF_NS bus_clk_o = ~bus_clk_o;
  end
  // Wired-OR of pull-downs, pull-up level when all release
  assign err_n_o = ~(err_oe_i | pull_i);
  assign bpm_n_o = ~bpm_oe_i;
endmodule : ces_peer
`default_nettype wire

// ==== test/tb_top.sv ====
// Purpose: Self-checking bench for the error and debug sideband block
// Assumes: Pulse length shortened to 4 bus clocks of 4 system clocks each
// Notes:   Bus clock phase makes pulse length vary by one bus clock
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ces_pkg::*;
  localparam int unsigned P = 4;  // Shortened pulse length
  logic       clk, srst, warm, mc_err, int_err, pull;  // Bench-driven inputs
  logic [7:0] status;                                  // Breakpoint status
  logic       bus_clk, err_n, err_o, err_oe, pr_p, pr_n, mc_exc;
  logic [7:0] bpm_line, bpm_o, bpm_oe;                 // Breakpoint bus
  int         mismatches, num_checks;                  // Verdict counters
  ces_top #(.PULSE_BCLKS(P)) dut (.sys_clk_i(clk), .srst_i(srst), .warm_reset_i(warm),
    .bus_clk_i(bus_clk), .mc_error_i(mc_err), .int_error_i(int_err), .bpm_status_i(status),
    .catastrophic_error_n_n_i(err_n), .catastrophic_error_n_n_o(err_o), .catastrophic_error_n_n_oe_o(err_oe), .bpm_n_i(bpm_line),
    .bpm_n_o(bpm_o), .bpm_n_oe_o(bpm_oe), .probe_clock_out_p_o(pr_p),
    .probe_clock_out_n_o(pr_n), .machine_check_o(mc_exc));
  ces_peer peer (.pull_i(pull), .err_oe_i(err_oe), .bpm_oe_i(bpm_oe), .bus_clk_o(bus_clk),
    .err_n_o(err_n), .bpm_n_o(bpm_line));
  // 200 MHz system clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Single-bit and vector comparisons
  task automatic chk1(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %0t: bit got %b exp %b", $time, got, exp);
    end
  endtask : chk1
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %0t: vector got %h exp %h", $time, got, exp);
    end
  endtask : chk8
  // Walk one status bit across the bus
  task automatic t_bpm();
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      status <= 8'h01 << i;
      @(posedge clk);
      #1 chk8(bpm_oe, 8'h01 << i);
      chk8(bpm_line, ~(8'h01 << i));
      chk8(bpm_o, 8'h00);
    end
  endtask : t_bpm
  // Probe pair follows the sampled bus clock
  task automatic t_probe();
    logic [2:0] hist;
    hist = 3'h0;
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      hist = {hist[1:0], bus_clk};
      #1 chk1(pr_n, ~pr_p);
      if (i > 3) chk1(pr_p, hist[2]);
    end
  endtask : t_probe
  // Machine-check pulse, no self-triggered exception
  task automatic t_mc();
    int n;
    n = 0;
    @(posedge clk);
    mc_err <= 1'b1;
    @(posedge clk);
    mc_err <= 1'b0;
    #1 chk1(err_oe, 1'b1);
    while (err_oe === 1'b1 && n < 100) begin
      chk1(mc_exc, 1'b0);
      chk1(err_n, 1'b0);
      chk1(err_o, 1'b0);
      @(posedge clk);
      #1 n++;
    end
    chk1(n > (P - 1) * 4 && n <= P * 4, 1'b1);
    repeat (4) begin
      @(posedge clk);
      #1 chk1(mc_exc, 1'b0);
    end
  endtask : t_mc
  // Another agent pulls the line: one exception per low period
  task automatic t_ext();
    int hits;
    hits = 0;
    @(posedge clk);
    pull <= 1'b1;
    repeat (12) begin
      @(posedge clk);
      #1 hits += int'(mc_exc === 1'b1);
    end
    chk1(hits == 1, 1'b1);
    chk1(err_oe, 1'b0);
    @(posedge clk);
    pull <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : t_ext
  // Internal error holds until warm reset; machine check ignored meanwhile
  task automatic t_ie();
    @(posedge clk);
    mc_err <= 1'b1;
    @(posedge clk);
    mc_err <= 1'b0;
    int_err <= 1'b1;
    @(posedge clk);
    int_err <= 1'b0;
    mc_err <= 1'b1;
    @(posedge clk);
    mc_err <= 1'b0;
    repeat (100) begin
      @(posedge clk);
      #1 chk1(err_oe, 1'b1);
    end
    @(posedge clk);
    warm <= 1'b1;
    @(posedge clk);
    warm <= 1'b0;
    @(posedge clk);
    #1 chk1(err_oe, 1'b0);
    chk1(mc_exc, 1'b0);
    repeat (3) begin
      @(posedge clk);
      #1 chk1(mc_exc, 1'b0);
    end
  endtask : t_ie
  // Verdict and end of run
  task automatic complete_run();
    if (mismatches == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : complete_run
  // Hang guard, well beyond the few hundred cycles expected
  initial begin
    #100000;
    mismatches++;
    complete_run();
  end
  // Main sequence
  initial begin
    {srst, warm, mc_err, int_err, pull, status} = {1'b1, 12'h000};
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1 chk1(err_oe, 1'b0);
    t_bpm();
    t_probe();
    t_mc();
    t_ext();
    t_ie();
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
